// [dv/ddu_host.sv]
`default_nettype none
// ----
// host side: frames and strobe pin
// ----
module ddu_host (
  // serial pins
  output logic sclk,
  output logic sdin,
  output logic frame_sync_n,
  // strobe pin
  output logic load_strobe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // sclk idles high and stands still between frames
  initial begin
    sclk = 1'b1;
    sdin = 1'b1;
    frame_sync_n = 1'b1;
    load_strobe_n = 1'b1;
  end
  // msb first, 24 falls at 160 ns, acted on at sync rise
  task automatic send(input logic [23:0] f);
    frame_sync_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      sdin = f[i];
      #80 sclk = 1'b0;
      #80 sclk = 1'b1;
    end
    #80 frame_sync_n = 1'b1;
    // released line shows the inverse, not a stale bit
    sdin = ~f[0];
  endtask : send
  // strobe only moves while no frame is open
  task automatic set_strobe(input logic lvl);
    load_strobe_n = lvl;
  endtask : set_strobe
endmodule : ddu_host
`default_nettype wire

// [dv/ddu_update_ctrl_asserts.sv]
`default_nettype none
// ----
// update control checks
// ----
module ddu_update_ctrl_asserts (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // pins
  input wire logic frame_sync_n,
  input wire logic load_strobe_n,
  input wire logic hw_reset_n,
  input wire logic reset_level_select,
  // register state
  input wire logic [15:0] dac_a_code,
  input wire logic [15:0] input_a_code,
  input wire logic reference_off,
  input wire logic [3:0] load_mask_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  // clear code follows the select pin live
  logic [15:0] clr;
  assign clr = reset_level_select ? ddu_pkg::CODE_MID : ddu_pkg::CODE_ZERO;
  // reset pin held low long enough to pass its synchroniser
  sequence s_hw_low;
    $fell(hw_reset_n) ##1 !hw_reset_n [*6];
  endsequence
  // channel a masked with no frame and no reset in flight
  sequence s_quiet_masked;
    (frame_sync_n && hw_reset_n && load_mask_out[0]) [*8];
  endsequence
  a_power_on_clear: assert property ($rose(resetn) |-> dac_a_code == 16'h0000
    && load_mask_out == ddu_pkg::MASK_RESET && reference_off == ddu_pkg::REF_RESET)
    else $error("power-on state not clear");
  a_power_up_level: assert property ($rose(resetn) ##1 frame_sync_n [*8] |->
    dac_a_code == clr && input_a_code == clr)
    else $error("power-up level wrong");
  a_hw_reset_clear: assert property (s_hw_low |-> dac_a_code == clr && input_a_code == clr)
    else $error("hardware reset did not clear");
  a_hw_reset_block: assert property (!hw_reset_n [*8] |-> $stable(dac_a_code))
    else $error("update while reset low");
  a_strobe_copies: assert property ($fell(load_strobe_n) && hw_reset_n && frame_sync_n
    && !load_mask_out[0] |-> ##[2:8] dac_a_code == input_a_code)
    else $error("strobe fall did not copy");
  a_masked_holds: assert property (s_quiet_masked |-> $stable(dac_a_code))
    else $error("masked channel moved");
  a_cfg_after_frame: assert property ($changed(load_mask_out) || $changed(reference_off)
    |-> frame_sync_n && !$past(frame_sync_n, 8) && load_mask_out[2:1] == 2'b00)
    else $error("config changed outside a frame");
  a_input_after_frame: assert property ($changed(input_a_code) && hw_reset_n |-> frame_sync_n)
    else $error("input register changed without a frame");
endmodule : ddu_update_ctrl_asserts
`default_nettype wire

// [dv/dual_dac_update_reset_control_test.sv]
`default_nettype none
module dual_dac_update_reset_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // pins and reference model
  // ----
  logic clk, resetn, hw_reset_n, rls;
  wire sclk, sdin, fsn, ldn;
  logic [15:0] dac_a, dac_b, in_a, in_b;
  logic ref_off;
  logic [3:0] mask;
  int failures, n_checks;
  int ein[2], edac[2], emask, eref;
  int cmds[$] = '{1, 2, 3, 5, 7};
  ddu_update_ctrl #(.TIED_LOW_FRAMES(1)) dut (.clk(clk), .resetn(resetn), .sclk(sclk),
    .sdin(sdin), .frame_sync_n(fsn), .load_strobe_n(ldn), .hw_reset_n(hw_reset_n),
    .reset_level_select(rls), .dac_a_code(dac_a), .dac_b_code(dac_b), .input_a_code(in_a),
    .input_b_code(in_b), .reference_off(ref_off), .load_mask_out(mask));
  ddu_host host (.sclk(sclk), .sdin(sdin), .frame_sync_n(fsn), .load_strobe_n(ldn));
  // ----
  // compare and model tasks
  // ----
  task automatic cmp(input logic [15:0] got, input int exp);
    n_checks++;
    if (got !== exp[15:0]) begin
      failures++;
      $display("FAIL %0t got %h want %h", $time, got, exp[15:0]);
    end
  endtask : cmp
  // waits past the answer latency, then compares every output
  task automatic check_all();
    repeat (12) @(posedge clk);
    #2;
    cmp(dac_a, edac[0]);
    cmp(dac_b, edac[1]);
    cmp(in_a, ein[0]);
    cmp(in_b, ein[1]);
    cmp({12'h000, mask}, emask);
    cmp({15'h0000, ref_off}, eref);
  endtask : check_all
  task automatic clear_model();
    foreach (ein[i]) begin
      ein[i] = rls ? 32'h8000 : 32'h0;
      edac[i] = ein[i];
    end
  endtask : clear_model
  // address bit 0 picks channel a, bit 3 channel b
  task automatic wr(input int c, input int a, input int d);
    host.send({c[3:0], a[3:0], d[15:0]});
    if (c == 5) emask = d & 32'h9;
    if (c == 7) eref = d & 32'h1;
    if (c == 6) clear_model();
    for (int ch = 0; ch < 2; ch++) begin
      if (a[3 * ch] && (c == 1 || c == 3)) ein[ch] = d & 32'hffff;
      if (a[3 * ch] && (c == 2 || c == 3 || (c == 1 && !ldn))) edac[ch] = ein[ch];
    end
    check_all();
  endtask : wr
  // only a falling strobe copies, and only unmasked channels
  task automatic strobe(input logic lvl);
    host.set_strobe(lvl);
    for (int ch = 0; ch < 2; ch++)
      if (!lvl && !emask[3 * ch]) edac[ch] = ein[ch];
    check_all();
  endtask : strobe
  task automatic give_verdict();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict
  // ----
  // clock, watchdog and sequence
  // ----
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // whole run is near 133 us, so this only trips on a hang
  initial begin
    #1_000_000;
    failures++;
    give_verdict();
  end
  initial begin
    resetn = 1'b0;
    hw_reset_n = 1'b1;
    rls = 1'b1;
    failures = 0;
    n_checks = 0;
    emask = 0;
    eref = 0;
    void'($urandom(24344));
    repeat (10) @(posedge clk);
    #2 resetn = 1'b1;
    clear_model();
    check_all();
    // write codes 0001, 0010, 0011, 0101 and 0111 with random address and data, strobe high
    for (int k = 0; k < 20; k++) begin
      wr(cmds[k % 5], $urandom_range(15, 1), $urandom);
      if (k % 4 == 3) strobe(1'b0);
      if (k % 4 == 3) strobe(1'b1);
    end
    wr(5, 0, 0);
    strobe(1'b0);
    wr(1, 9, $urandom);
    wr(5, 0, 9);
    wr(1, 9, $urandom);
    strobe(1'b1);
    wr(1, 9, $urandom);
    strobe(1'b0);
    strobe(1'b1);
    wr(5, 0, 0);
    rls = 1'b0;
    wr(6, 0, 0);
    rls = 1'b1;
    hw_reset_n = 1'b0;
    clear_model();
    host.send(24'h395555);
    check_all();
    hw_reset_n = 1'b1;
    check_all();
    wr(3, 1, $urandom);
    // second power-on in mid-run: select low, strobe moving inside the window
    wr(5, 0, 9);
    wr(7, 0, 1);
    rls = 1'b0;
    resetn = 1'b0;
    @(posedge clk);
    #2 resetn = 1'b1;
    host.set_strobe(1'b0);
    emask = 0;
    eref = 0;
    clear_model();
    check_all();
    give_verdict();
  end
endmodule : dual_dac_update_reset_control_test
bind ddu_update_ctrl ddu_update_ctrl_asserts chk (.clk(clk), .resetn(resetn),
  .frame_sync_n(frame_sync_n), .load_strobe_n(load_strobe_n), .hw_reset_n(hw_reset_n),
  .reset_level_select(reset_level_select), .dac_a_code(dac_a_code),
  .input_a_code(input_a_code), .reference_off(reference_off), .load_mask_out(load_mask_out));
`default_nettype wire

// [hdl/ddu_frame_rx.sv]
`default_nettype none
// shift receiver: samples the serial pins in the system clock domain
module ddu_frame_rx (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // serial pins, already synchronised
  input wire logic sclk_s,
  input wire logic sdin_s,
  input wire logic frame_sync_n_s,
  // received frame
  output ddu_pkg::ddu_frame_s frame,
  output logic frame_valid
);
  logic sclk_d_reg;
  logic fs_d_reg;
  logic [23:0] shift_reg;
  logic [4:0] count_reg;
  logic frame_valid_reg;
  ddu_pkg::ddu_frame_s frame_reg;
  wire sclk_fall = sclk_d_reg & ~sclk_s;
  wire fs_rise = ~fs_d_reg & frame_sync_n_s;
  wire shift_en = sclk_fall & ~frame_sync_n_s;
  wire full = (count_reg >= 5'(ddu_pkg::FRAME_BITS));

  // data is taken on falling sclk while the frame is open
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sclk_d_reg <= 1'b1;
      fs_d_reg <= 1'b1;
      shift_reg <= 24'h000000;
      count_reg <= 5'h00;
      frame_valid_reg <= 1'b0;
      frame_reg <= '0;
    end else begin
      sclk_d_reg <= sclk_s;
      fs_d_reg <= frame_sync_n_s;
      frame_valid_reg <= 1'b0;
      if (shift_en) begin
        shift_reg <= {shift_reg[22:0], sdin_s};
        if (!full) count_reg <= count_reg + 5'h01;
      end
      // frame is acted on at the rising edge of sync; short frames are dropped
      if (fs_rise) begin
        count_reg <= 5'h00;
        if (full) begin
          frame_valid_reg <= 1'b1;
          frame_reg <= shift_reg;
        end
      end
    end
  end

  assign frame = frame_reg;
  assign frame_valid = frame_valid_reg;
endmodule : ddu_frame_rx
`default_nettype wire

// [hdl/ddu_pkg.sv]
`default_nettype none
package ddu_pkg;
  // frame geometry
  localparam int unsigned FRAME_BITS = 24;
  localparam int unsigned CMD_MSB = 23;
  localparam int unsigned CMD_LSB = 20;
  localparam int unsigned ADDR_MSB = 19;
  localparam int unsigned ADDR_LSB = 16;
  localparam int unsigned DATA_MSB = 15;
  localparam int unsigned DATA_LSB = 0;
  localparam int unsigned DATA_BITS = 16;
  // address bits select channels
  localparam int unsigned ADDR_CH_A = 0;
  localparam int unsigned ADDR_CH_B = 3;
  // load mask field positions
  localparam int unsigned MASK_BIT_A = 0;
  localparam int unsigned MASK_BIT_B = 3;
  localparam int unsigned MASK_WIDTH = 4;
  localparam logic [3:0] MASK_RESET = 4'h0;
  // reference setup bit
  localparam int unsigned REF_BIT = 0;
  localparam logic REF_RESET = 1'b0;
  // clear codes
  localparam logic [15:0] CODE_ZERO = 16'h0000;
  localparam logic [15:0] CODE_MID = 16'h8000;
  // low time of the hardware reset pin before it takes effect
  localparam int unsigned RESET_MIN_NS = 20;
  localparam int unsigned CLK_NS = 20;
  localparam int unsigned RESET_MIN_CYC = (RESET_MIN_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [3:0] {
    DDU_CMD_NOP = 4'h0,
    DDU_CMD_WR_IN = 4'h1,
    DDU_CMD_UPD = 4'h2,
    DDU_CMD_WR_UPD = 4'h3,
    DDU_CMD_PDN = 4'h4,
    DDU_CMD_MASK = 4'h5,
    DDU_CMD_SWRST = 4'h6,
    DDU_CMD_REF = 4'h7
  } ddu_cmd_e;

  // one received frame, split into its fields
  typedef struct packed {
    logic [3:0] cmd;
    logic [3:0] addr;
    logic [15:0] data;
  } ddu_frame_s;
endpackage : ddu_pkg
`default_nettype wire

// [hdl/ddu_update_ctrl.sv]
`default_nettype none
// Notes on behaviour
// - 24-bit frame acted on when sync rises
// - strobe low: write updates input and DAC
// - strobe falling after frame updates DAC registers
// - command 0101 loads mask, address ignored
// - channel B mask DB3, channel A DB0
// - mask bits default zero, strobe controls
// - masked channel sees strobe as high
// - strobe high: write touches input only
// - command 0010 copies input to DAC
// - command 0011 writes input and DAC
// - strobe fall copies unmasked channels
// - strobe tied low ignores mask bits
// - hardware reset clears to selected code
// - reset blocks updates, cleared value holds
// - command 0110 restores power-on code; the code loads the clear code from the live select pin instead
// - power-on reset ignores strobe and reset
// - power-up code chosen by select pin
// - command 0111 sets reference off bit
// - command in DB23-20, address DB19-16
module ddu_update_ctrl #(
  parameter int unsigned CHANNELS = 2,
  parameter int unsigned TIED_LOW_FRAMES = 1
) (
  // clock and power-on reset
  input wire logic clk,
  input wire logic resetn,
  // serial link from the host
  input wire logic sclk,
  input wire logic sdin,
  input wire logic frame_sync_n,
  // control pins
  input wire logic load_strobe_n,
  input wire logic hw_reset_n,
  input wire logic reset_level_select,
  // converter side
  output logic [15:0] dac_a_code,
  output logic [15:0] dac_b_code,
  output logic [15:0] input_a_code,
  output logic [15:0] input_b_code,
  output logic reference_off,
  output logic [3:0] load_mask_out
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [5:0] sync1_reg;
  logic [5:0] sync2_reg;
  // first stage feeds only the second; all pins but sdin start high
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync1_reg <= 6'h3d;
      sync2_reg <= 6'h3d;
    end else begin
      sync1_reg <= {load_strobe_n, hw_reset_n, frame_sync_n, reset_level_select, sdin, sclk};
      sync2_reg <= sync1_reg;
    end
  end
  wire sclk_s = sync2_reg[0];
  wire sdin_s = sync2_reg[1];
  wire sel_s = sync2_reg[2];
  wire fs_s = sync2_reg[3];
  wire hwrst_s = sync2_reg[4];
  wire ld_s = sync2_reg[5];

  // ----------------------------------------------------------------
  // frame receiver
  // ----------------------------------------------------------------
  ddu_pkg::ddu_frame_s frame;
  logic frame_valid;
  ddu_frame_rx u_rx (
    .clk(clk),
    .resetn(resetn),
    .sclk_s(sclk_s),
    .sdin_s(sdin_s),
    .frame_sync_n_s(fs_s),
    .frame(frame),
    .frame_valid(frame_valid)
  );

  // ----------------------------------------------------------------
  // power-on window and live strap decode
  // ----------------------------------------------------------------
  // the reset-level strap is only valid once synchronised, so the
  // power-on period lasts until the pipeline has filled
  logic [1:0] por_cnt_reg;
  logic por_busy_reg;
  logic ld_d_reg;
  logic hw_cnt_done;
  logic [7:0] hw_cnt_reg;
  wire por_done_now = por_busy_reg & (por_cnt_reg == 2'h3);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      por_cnt_reg <= 2'h0;
      por_busy_reg <= 1'b1;
    end else if (por_busy_reg) begin
      por_cnt_reg <= por_cnt_reg + 2'h1;
      if (por_done_now) por_busy_reg <= 1'b0;
    end
  end
  wire [15:0] clear_code = sel_s ? ddu_pkg::CODE_MID : ddu_pkg::CODE_ZERO;

  // ----------------------------------------------------------------
  // hardware reset: must stay low a minimum time to act
  // ----------------------------------------------------------------
  // counts low cycles; pin activity during power-on is ignored
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hw_cnt_reg <= 8'h00;
    end else if (por_busy_reg || hwrst_s) begin
      hw_cnt_reg <= 8'h00;
    end else if (!hw_cnt_done) begin
      hw_cnt_reg <= hw_cnt_reg + 8'h01;
    end
  end
  assign hw_cnt_done = (hw_cnt_reg >= 8'(ddu_pkg::RESET_MIN_CYC));
  wire hw_active = ~por_busy_reg & ~hwrst_s;
  wire hw_clear = hw_active & hw_cnt_done;

  // ----------------------------------------------------------------
  // strobe edge and tied-low detection
  // ----------------------------------------------------------------
  // a strobe that stays low across whole frames counts as tied low;
  // then the mask is bypassed so instantaneous updates still work
  logic [7:0] low_frames_reg;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ld_d_reg <= 1'b1;
      low_frames_reg <= 8'h00;
    end else begin
      ld_d_reg <= ld_s;
      if (ld_s) low_frames_reg <= 8'h00;
      else if (frame_valid && low_frames_reg != 8'hff) low_frames_reg <= low_frames_reg + 8'h01;
    end
  end
  wire ld_fall = ld_d_reg & ~ld_s & ~por_busy_reg;
  wire tied_low = (low_frames_reg >= 8'(TIED_LOW_FRAMES)) & ~ld_s;

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  wire [3:0] cmd = frame.cmd;
  wire [3:0] addr = frame.addr;
  wire is_wr_in = frame_valid & (cmd == ddu_pkg::DDU_CMD_WR_IN);
  wire is_upd = frame_valid & (cmd == ddu_pkg::DDU_CMD_UPD);
  wire is_wr_upd = frame_valid & (cmd == ddu_pkg::DDU_CMD_WR_UPD);
  wire is_mask = frame_valid & (cmd == ddu_pkg::DDU_CMD_MASK);
  wire is_swrst = frame_valid & (cmd == ddu_pkg::DDU_CMD_SWRST);
  wire is_ref = frame_valid & (cmd == ddu_pkg::DDU_CMD_REF);

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic [3:0] load_mask_reg;
  logic reference_setup_reg;
  wire [3:0] mask_next = {frame.data[ddu_pkg::MASK_BIT_B], 2'b00,
                          frame.data[ddu_pkg::MASK_BIT_A]};
  // mask and reference bit keep their values across the hardware reset pin
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      load_mask_reg <= ddu_pkg::MASK_RESET;
      reference_setup_reg <= ddu_pkg::REF_RESET;
    end else begin
      if (is_mask) load_mask_reg <= mask_next;
      if (is_ref) reference_setup_reg <= frame.data[ddu_pkg::REF_BIT];
    end
  end

  // ----------------------------------------------------------------
  // per-channel input and DAC registers
  // ----------------------------------------------------------------
  logic [15:0] in_reg [CHANNELS];
  logic [15:0] dac_reg [CHANNELS];
  localparam int unsigned CH_ADDR [2] = '{ddu_pkg::ADDR_CH_A, ddu_pkg::ADDR_CH_B};
  localparam int unsigned CH_MASK [2] = '{ddu_pkg::MASK_BIT_A, ddu_pkg::MASK_BIT_B};

  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : g_ch
      wire sel = addr[CH_ADDR[ch]];
      wire masked = load_mask_reg[CH_MASK[ch]] & ~tied_low;
      wire ld_eff_low = ~ld_s & ~masked;
      wire wr_in = is_wr_in & sel;
      wire wr_dac_direct = (is_wr_in & sel & ld_eff_low) | (is_wr_upd & sel);
      wire copy = (is_upd & sel) | (ld_fall & ~masked);
      wire blocked = hw_active;
      wire restore = hw_clear | is_swrst | por_done_now;

      // input register: written by 0001 and 0011 frames
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          in_reg[ch] <= ddu_pkg::CODE_ZERO;
        end else if (restore) begin
          in_reg[ch] <= clear_code;
        end else if (!blocked && (wr_in || (is_wr_upd && sel))) begin
          in_reg[ch] <= frame.data;
        end
      end

      // dac register: direct write wins over a copy in the same cycle
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          dac_reg[ch] <= ddu_pkg::CODE_ZERO;
        end else if (restore) begin
          dac_reg[ch] <= clear_code;
        end else if (!blocked) begin
          if (wr_dac_direct) dac_reg[ch] <= frame.data;
          else if (copy) dac_reg[ch] <= in_reg[ch];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // outputs, all registered
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dac_a_code <= ddu_pkg::CODE_ZERO;
      dac_b_code <= ddu_pkg::CODE_ZERO;
      input_a_code <= ddu_pkg::CODE_ZERO;
      input_b_code <= ddu_pkg::CODE_ZERO;
      reference_off <= 1'b0;
      load_mask_out <= ddu_pkg::MASK_RESET;
    end else begin
      dac_a_code <= dac_reg[0];
      dac_b_code <= dac_reg[1];
      input_a_code <= in_reg[0];
      input_b_code <= in_reg[1];
      reference_off <= reference_setup_reg;
      load_mask_out <= load_mask_reg;
    end
  end
endmodule : ddu_update_ctrl
`default_nettype wire
